// >>> wtw_regs.vh
// Timing constants for the wake timer watchdog block
`ifndef WTW_REGS_VH
`define WTW_REGS_VH

// System clock period and the millisecond base, in ns
`define WTW_CLK_NS 8'h14
`define WTW_MS_NS 20'hF4240
// Cycles of ref_clk per 1 ms enable tick: 1 ms over 20 ns
`define WTW_MS_CYCLES 16'hC350

// Slow oscillator period in ms (manual reset sampling rate)
`define WTW_OSC_MS 4'hA

// Interval limits in ms: 100 ms .. 7200 s
`define WTW_IV_MIN_MS 23'h000064
`define WTW_IV_MAX_MS 23'h6DDD00

// Pulse widths and deadlines in ms
`define WTW_WAKE_MS 23'h000014
`define WTW_RST_MS 23'h000140
`define WTW_ACK_LEAD_MS 23'h000014
`define WTW_MEAS_MAX_MS 23'h000078

// Consecutive slow-oscillator samples for a valid manual reset
`define WTW_MR_SAMPLES 2'h2

`endif

// >>> wtw_mr_debounce.v
// Manual reset pin synchroniser and slow-oscillator debouncer
`timescale 1ns/1ps
`default_nettype none
`include "wtw_regs.vh"

module wtw_mr_debounce (
  input wire ref_clk,
  input wire srst,
  input wire pin_in,
  input wire osc_tick,
  input wire clear,
  output wire mr_active
);

  reg sync1_reg;
  reg sync2_reg;
  reg [1:0] high_cnt_reg;
  reg [1:0] low_cnt_reg;
  reg active_reg;

  // Two-stage synchroniser, first stage feeds only the second
  always @(posedge ref_clk) begin
    if (srst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Sample once per slow cycle; glitches between samples are unseen
  always @(posedge ref_clk) begin
    if (srst || clear) begin
      high_cnt_reg <= 2'h0;
      low_cnt_reg <= 2'h0;
      active_reg <= 1'b0;
    end else if (osc_tick) begin
      if (sync2_reg) begin
        low_cnt_reg <= 2'h0;
        if (high_cnt_reg != `WTW_MR_SAMPLES)
          high_cnt_reg <= high_cnt_reg + 2'h1;
        if (high_cnt_reg == `WTW_MR_SAMPLES - 2'h1)
          active_reg <= 1'b1;
      end else begin
        high_cnt_reg <= 2'h0;
        if (low_cnt_reg != `WTW_MR_SAMPLES)
          low_cnt_reg <= low_cnt_reg + 2'h1;
        // Release is debounced too, so a bouncing switch stays held
        if (low_cnt_reg == `WTW_MR_SAMPLES - 2'h1)
          active_reg <= 1'b0;
      end
    end
  end

  assign mr_active = active_reg;

endmodule // wtw_mr_debounce
`default_nettype wire

// >>> wtw_wake_timer_watchdog.v
// Wake timer with watchdog reset, manual reset and start-up measurement
`timescale 1ns/1ps
`default_nettype none
`include "wtw_regs.vh"

module wtw_wake_timer_watchdog #(
  parameter [15:0] MS_CYCLES = `WTW_MS_CYCLES
) (
  input wire ref_clk,
  input wire srst,
  // Digital level of the shared interval / manual reset pin
  input wire mrst_pin,
  // Acknowledge from the host, asynchronous
  input wire ack_in,
  // Converter result: interval in ms, one-cycle valid
  input wire meas_valid,
  input wire [22:0] meas_interval_ms,
  // Pin routed to the analog converter while high
  output wire meas_en,
  output wire wake_out,
  // Open-drain reset: level and drive enable
  output wire host_reset_out_n,
  output wire host_reset_oe
);

  // Operating states. Power-on and srst enter ST_MEAS; a valid
  // manual reset parks in ST_MRHOLD until the pin is released;
  // ST_RST is the fixed host reset pulse; ST_RUN counts intervals.
  // Manual reset may interrupt any state, so ST_MRHOLD remembers
  // through measured_reg whether the measurement still has to run.
  localparam [1:0] ST_MEAS = 2'h0;
  localparam [1:0] ST_MRHOLD = 2'h1;
  localparam [1:0] ST_RST = 2'h2;
  localparam [1:0] ST_RUN = 2'h3;

  // Sequencer state
  reg [1:0] state_reg;

  // Millisecond and slow oscillator time base
  reg [15:0] ms_div_reg;
  reg ms_tick_reg;
  reg [15:0] osc_ms_div_reg;
  reg [3:0] osc_div_reg;
  reg osc_tick_reg;

  // Interval length and its running count, in ms
  reg [22:0] iv_cnt_reg;
  reg [22:0] interval_reg;

  // Reset pulse, measurement timeout and wake width counts, in ms
  reg [22:0] pulse_cnt_reg;
  reg [22:0] wake_cnt_reg;

  // Start-up status and registered outputs
  reg measured_reg;
  reg meas_en_reg;
  reg wake_reg;
  reg rst_n_reg;

  // Watchdog flags: edge taken this interval, edge was in time
  reg ack_taken_reg;
  reg ack_ok_reg;

  // Acknowledge synchroniser and edge history
  reg ack_s1_reg;
  reg ack_s2_reg;
  reg ack_s3_reg;

  // Debounced manual reset and the counter freeze it causes
  wire mr_active;
  wire hold_counters;

  // One-cycle acknowledge edge, already synchronised
  wire ack_rise;

  // Interval end points and the clamped converter result
  wire [22:0] iv_last;
  wire [22:0] ack_deadline;
  wire [22:0] meas_clamped;

  // Counters are frozen and cleared while a manual reset is held
  assign hold_counters = (state_reg == ST_MRHOLD) | mr_active;

  // Last ms count of an interval and the acknowledge deadline
  assign iv_last = interval_reg - 23'h000001;
  assign ack_deadline = interval_reg - `WTW_ACK_LEAD_MS;

  // Keep the converter answer inside the legal interval range
  assign meas_clamped =
    (meas_interval_ms < `WTW_IV_MIN_MS) ? `WTW_IV_MIN_MS :
    (meas_interval_ms > `WTW_IV_MAX_MS) ? `WTW_IV_MAX_MS :
    meas_interval_ms;

  // Millisecond enable, restarted by a manual reset. Frozen while
  // the switch is held, so the reset pulse after the release is
  // counted from a clean phase.
  always @(posedge ref_clk) begin
    if (srst || hold_counters) begin
      ms_div_reg <= 16'h0000;
      ms_tick_reg <= 1'b0;
    end else if (ms_div_reg == MS_CYCLES - 16'h0001) begin
      ms_div_reg <= 16'h0000;
      ms_tick_reg <= 1'b1;
    end else begin
      ms_div_reg <= ms_div_reg + 16'h0001;
      ms_tick_reg <= 1'b0;
    end
  end

  // Slow oscillator tick; runs on even during a manual reset
  // because the debouncer needs it to see the release
  always @(posedge ref_clk) begin
    if (srst) begin
      osc_ms_div_reg <= 16'h0000;
      osc_div_reg <= 4'h0;
      osc_tick_reg <= 1'b0;
    end else begin
      osc_tick_reg <= 1'b0;
      if (osc_ms_div_reg == MS_CYCLES - 16'h0001) begin
        osc_ms_div_reg <= 16'h0000;
        if (osc_div_reg == `WTW_OSC_MS - 4'h1) begin
          osc_div_reg <= 4'h0;
          osc_tick_reg <= 1'b1;
        end else begin
          osc_div_reg <= osc_div_reg + 4'h1;
        end
      end else begin
        osc_ms_div_reg <= osc_ms_div_reg + 16'h0001;
      end
    end
  end

  // Manual reset detection with debounce; clear stays low because
  // the release must be judged from the same sample history
  wtw_mr_debounce u_mr_debounce (
    .ref_clk(ref_clk),
    .srst(srst),
    .pin_in(mrst_pin),
    .osc_tick(osc_tick_reg),
    .clear(1'b0),
    .mr_active(mr_active)
  );

  // Acknowledge synchroniser and edge detector; the pin pulse can be
  // short, so only the fast clock can catch it
  always @(posedge ref_clk) begin
    if (srst) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      ack_s3_reg <= 1'b0;
    end else begin
      ack_s1_reg <= ack_in;
      ack_s2_reg <= ack_s1_reg;
      ack_s3_reg <= ack_s2_reg;
    end
  end

  assign ack_rise = ack_s2_reg & ~ack_s3_reg;

  // Main sequencer. Priority is srst, then manual reset, then the
  // state itself, so a held switch overrides measurement, pulse and
  // interval alike; within ST_RUN the interval boundary is written
  // last and wins over an acknowledge edge in the same cycle.
  always @(posedge ref_clk) begin
    if (srst) begin
      // Power-on: measure first, host held in reset
      state_reg <= ST_MEAS;
      measured_reg <= 1'b0;
      meas_en_reg <= 1'b1;
      interval_reg <= `WTW_IV_MIN_MS;
      iv_cnt_reg <= 23'h000000;
      pulse_cnt_reg <= 23'h000000;
      wake_cnt_reg <= 23'h000000;
      wake_reg <= 1'b0;
      rst_n_reg <= 1'b0;
      ack_taken_reg <= 1'b0;
      ack_ok_reg <= 1'b0;
    end else if (mr_active) begin
      // Manual reset wins over every state and clears the interval, pulse and wake counters
      state_reg <= ST_MRHOLD;
      meas_en_reg <= 1'b0;
      iv_cnt_reg <= 23'h000000;
      pulse_cnt_reg <= 23'h000000;
      wake_cnt_reg <= 23'h000000;
      wake_reg <= 1'b0;
      rst_n_reg <= 1'b0;
      ack_taken_reg <= 1'b0;
      ack_ok_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_MEAS: begin
          // One-time conversion; a late converter falls back to
          // the shortest interval so start-up never stalls
          rst_n_reg <= 1'b0;
          wake_reg <= 1'b0;
          if (meas_valid) begin
            interval_reg <= meas_clamped;
            measured_reg <= 1'b1;
            meas_en_reg <= 1'b0;
            state_reg <= ST_RUN;
            rst_n_reg <= 1'b1;
            iv_cnt_reg <= 23'h000000;
            ack_taken_reg <= 1'b0;
            ack_ok_reg <= 1'b1;
          end else if (ms_tick_reg) begin
            if (pulse_cnt_reg == `WTW_MEAS_MAX_MS - 23'h000001) begin
              interval_reg <= `WTW_IV_MIN_MS;
              measured_reg <= 1'b1;
              meas_en_reg <= 1'b0;
              state_reg <= ST_RUN;
              rst_n_reg <= 1'b1;
              iv_cnt_reg <= 23'h000000;
              ack_taken_reg <= 1'b0;
              ack_ok_reg <= 1'b1;
            end else begin
              pulse_cnt_reg <= pulse_cnt_reg + 23'h000001;
            end
          end
        end

        ST_MRHOLD: begin
          // Released: redo an aborted measurement, else one pulse
          rst_n_reg <= 1'b0;
          wake_reg <= 1'b0;
          pulse_cnt_reg <= 23'h000000;
          if (measured_reg) begin
            state_reg <= ST_RST;
          end else begin
            state_reg <= ST_MEAS;
            meas_en_reg <= 1'b1;
          end
        end

        ST_RST: begin
          // Fixed reset pulse; the host restarts, so the following
          // interval ends in a wake without an acknowledge
          rst_n_reg <= 1'b0;
          wake_reg <= 1'b0;
          if (ms_tick_reg) begin
            if (pulse_cnt_reg == `WTW_RST_MS - 23'h000001) begin
              state_reg <= ST_RUN;
              rst_n_reg <= 1'b1;
              pulse_cnt_reg <= 23'h000000;
              iv_cnt_reg <= 23'h000000;
              ack_taken_reg <= 1'b0;
              ack_ok_reg <= 1'b1;
            end else begin
              pulse_cnt_reg <= pulse_cnt_reg + 23'h000001;
            end
          end
        end

        ST_RUN: begin
          rst_n_reg <= 1'b1;
          // First edge per interval only; later ones are ignored
          if (ack_rise && !ack_taken_reg) begin
            ack_taken_reg <= 1'b1;
            wake_reg <= 1'b0;
            // Only the watchdog flag moves, never the interval count
            if (iv_cnt_reg < ack_deadline)
              ack_ok_reg <= 1'b1;
          end

          // Wake pulse width in whole ms
          if (ms_tick_reg && wake_reg) begin
            if (wake_cnt_reg == `WTW_WAKE_MS - 23'h000001) begin
              wake_reg <= 1'b0;
              wake_cnt_reg <= 23'h000000;
            end else begin
              wake_cnt_reg <= wake_cnt_reg + 23'h000001;
            end
          end

          // Interval boundary decides wake or watchdog reset
          if (ms_tick_reg) begin
            if (iv_cnt_reg == iv_last) begin
              iv_cnt_reg <= 23'h000000;
              ack_taken_reg <= 1'b0;
              ack_ok_reg <= 1'b0;
              wake_cnt_reg <= 23'h000000;
              if (ack_ok_reg) begin
                wake_reg <= 1'b1;
              end else begin
                wake_reg <= 1'b0;
                rst_n_reg <= 1'b0;
                state_reg <= ST_RST;
                pulse_cnt_reg <= 23'h000000;
              end
            end else begin
              iv_cnt_reg <= iv_cnt_reg + 23'h000001;
            end
          end
        end

        default: begin
          state_reg <= ST_MEAS;
          rst_n_reg <= 1'b0;
          wake_reg <= 1'b0;
        end
      endcase
    end
  end

  // Outputs straight from flip-flops
  assign meas_en = meas_en_reg;
  assign wake_out = wake_reg;

  // Open drain: drive low only, pull-up makes the high level.
  // A released line rises only as fast as the pull-up charges it,
  // so a slow rise lengthens the host reset but never shortens it.
  assign host_reset_out_n = 1'b0;
  assign host_reset_oe = ~rst_n_reg;

endmodule // wtw_wake_timer_watchdog
`default_nettype wire

// >>> wtw_monitor.sv
// Port checker for the wake timer watchdog
`timescale 1ns/1ps
`default_nettype none
module wtw_monitor #(
  parameter [15:0] MS_CYCLES = 16'h0004
) (
  input wire ref_clk,
  input wire srst,
  input wire mrst_pin,
  input wire ack_in,
  input wire meas_valid,
  input wire [22:0] meas_interval_ms,
  input wire meas_en,
  input wire wake_out,
  input wire host_reset_out_n,
  input wire host_reset_oe
);
  localparam int WAKE_MAX = 20 * MS_CYCLES + 1;
  localparam int MEAS_MAX = 120 * MS_CYCLES + 2;
  localparam int PIN_MAX = 22 * MS_CYCLES;
  int wake_cnt_reg = 0;
  int gap_cnt_reg = 0;
  int meas_cnt_reg = 0;
  int pin_cnt_reg = 0;
  int iv_reg = 0;
  logic wake_d_reg = 1'b0;
  wire rise_now = wake_out && !wake_d_reg;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  // Counters; any reset pulse voids the spacing count (interval restarts)
  always @(posedge ref_clk) begin
    wake_d_reg <= wake_out;
    wake_cnt_reg <= wake_out ? wake_cnt_reg + 1 : 0;
    meas_cnt_reg <= (meas_en && !srst) ? meas_cnt_reg + 1 : 0;
    pin_cnt_reg <= mrst_pin ? pin_cnt_reg + 1 : 0;
    if (srst || host_reset_oe) begin
      gap_cnt_reg <= -1000000;
    end else begin
      gap_cnt_reg <= rise_now ? 1 : gap_cnt_reg + 1;
    end
    // Results below the shortest interval are raised to it
    if (meas_en && meas_valid) begin
      iv_reg <= (meas_interval_ms < 23'h000064) ? 100
        : int'(meas_interval_ms);
    end
  end
  a_meas_holds_reset:
    assert property (meas_en |-> host_reset_oe) else $error("reset free");
  a_srst_defaults:
    assert property (disable iff (1'b0) srst |=> meas_en && host_reset_oe
      && !wake_out) else $error("bad reset state");
  a_wake_needs_run:
    assert property ($rose(wake_out) |-> !meas_en && !host_reset_oe)
      else $error("wake outside run");
  a_reset_quiets_wake:
    assert property (host_reset_oe |-> !wake_out) else $error("wake in reset");
  a_ack_ends_wake:
    assert property ($rose(ack_in) && wake_out |-> ##[1:5] !wake_out)
      else $error("wake not cut");
  a_wake_width_max:
    assert property (wake_cnt_reg <= WAKE_MAX) else $error("wake too long");
  a_wake_spacing:
    assert property (rise_now |-> gap_cnt_reg < 0
      || gap_cnt_reg == iv_reg * MS_CYCLES) else $error("wake spacing");
  a_meas_bounded:
    assert property (meas_cnt_reg <= MEAS_MAX) else $error("measure long");
  a_meas_exit:
    assert property (meas_en && meas_valid && !mrst_pin |=> !meas_en
      && !host_reset_oe) else $error("measure exit");
  a_manual_takes:
    assert property (pin_cnt_reg > PIN_MAX |-> host_reset_oe)
      else $error("manual reset missed");
endmodule // wtw_monitor
bind wtw_wake_timer_watchdog wtw_monitor #(.MS_CYCLES(MS_CYCLES))
  i_wtw_monitor (
  .ref_clk(ref_clk),
  .srst(srst),
  .mrst_pin(mrst_pin),
  .ack_in(ack_in),
  .meas_valid(meas_valid),
  .meas_interval_ms(meas_interval_ms),
  .meas_en(meas_en),
  .wake_out(wake_out),
  .host_reset_out_n(host_reset_out_n),
  .host_reset_oe(host_reset_oe)
);
`default_nettype wire

// >>> wtw_host_model.sv
// Host controller model answering wake pulses with an acknowledge
`timescale 1ns/1ps
`default_nettype none
module wtw_host_model (
  input wire logic ref_clk,
  input wire logic wake_out,
  input wire logic host_reset_oe,
  input wire logic [1:0] mode,
  input wire logic [31:0] delay,
  output var logic ack_in
);
  initial ack_in = 1'b0;
  // Modes: 0 silent, 1 two edges, 2 one edge, 3 edge then level held
  always @(posedge wake_out) begin
    if (mode != 2'h0) begin
      repeat (delay) @(negedge ref_clk);
      ack_in <= 1'b1;
      repeat (3) @(negedge ref_clk);
      ack_in <= (mode == 2'h3);
      if (mode == 2'h1) begin
        // Second edge in the same interval must be ignored
        repeat (3) @(negedge ref_clk);
        ack_in <= 1'b1;
        repeat (3) @(negedge ref_clk);
        ack_in <= 1'b0;
      end
    end
  end
  // A host held in reset lets its acknowledge line fall
  always @(posedge host_reset_oe) ack_in <= 1'b0;
endmodule // wtw_host_model
`default_nettype wire

// >>> wtw_wake_timer_watchdog_tb.sv
// Self-checking bench for the wake timer watchdog
`timescale 1ns/1ps
`default_nettype none
module wtw_wake_timer_watchdog_tb;
  localparam int M = 4;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic mrst_pin = 1'b0;
  logic meas_valid = 1'b0;
  logic [22:0] meas_interval_ms = 23'h000000;
  logic ack_in, meas_en, wake_out, host_reset_out_n, host_reset_oe;
  logic [1:0] mode = 2'h0;
  logic [31:0] delay = 32'h0000000A;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int iv, t, at, p;
  always #10 ref_clk = ~ref_clk;
  wtw_wake_timer_watchdog #(.MS_CYCLES(16'h0004)) i_wtw_wake_timer_watchdog (
    .ref_clk(ref_clk), .srst(srst), .mrst_pin(mrst_pin), .ack_in(ack_in),
    .meas_valid(meas_valid), .meas_interval_ms(meas_interval_ms),
    .meas_en(meas_en), .wake_out(wake_out),
    .host_reset_out_n(host_reset_out_n), .host_reset_oe(host_reset_oe));
  wtw_host_model i_wtw_host_model (.ref_clk(ref_clk), .wake_out(wake_out),
    .host_reset_oe(host_reset_oe), .mode(mode), .delay(delay),
    .ack_in(ack_in));
  task automatic results();
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Run takes about 10k cycles; the ceiling leaves ample slack
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count += 1;
      results();
    end
  end
  task automatic chk(input int got, input int exp, input int tol);
    num_checks += 1;
    if (got < exp - tol || got > exp + tol) begin
      err_count += 1;
      $display("BAD %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // Case equality so an unknown flag never passes
  task automatic chk_bit(input logic got, input logic exp);
    num_checks += 1;
    if (got !== exp) begin
      err_count += 1;
      $display("BAD %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  function automatic logic sig(input int k);
    return k == 0 ? wake_out : (k == 1 ? host_reset_oe : meas_en);
  endfunction
  // Bounded by the global cycle ceiling
  task automatic wait_for(input int k, input logic v, output int w);
    while (sig(k) !== v) @(negedge ref_clk);
    w = cyc;
  endtask
  // Wake one interval after t0, then its width
  task automatic next_wake(inout int t0, input int tol, input int w);
    int r;
    int f;
    wait_for(0, 1'b1, r);
    chk(r - t0, iv * M, tol);
    wait_for(0, 1'b0, f);
    chk(f - r, w, 3);
    t0 = r;
  endtask
  // Missed interval: reset at the boundary, then one reset pulse
  task automatic miss(inout int t0);
    int r;
    wait_for(1, 1'b1, r);
    chk(r - t0, iv * M, 1);
    chk_bit(wake_out, 1'b0);
    wait_for(1, 1'b0, t0);
    chk(t0 - r, 320 * M, 1);
  endtask
  initial begin
    iv = $urandom(32'hAAAC);
    iv = 100 + $urandom % 50;
    delay = 5 + $urandom % 10;
    repeat (5) @(negedge ref_clk);
    srst = 1'b0;
    chk_bit(meas_en, 1'b1);
    chk_bit(host_reset_oe, 1'b1);
    chk_bit(host_reset_out_n, 1'b0);
    repeat (7) @(negedge ref_clk);
    meas_interval_ms = iv[22:0];
    meas_valid = 1'b1;
    @(negedge ref_clk);
    meas_valid = 1'b0;
    t = cyc;
    chk_bit(meas_en, 1'b0);
    chk_bit(host_reset_oe, 1'b0);
    mode = 2'h3;
    next_wake(t, M, delay + 4);
    next_wake(t, 0, 20 * M);
    miss(t);
    mode = 2'h2;
    delay = iv * M - 10 * M;
    next_wake(t, 1, 20 * M);
    miss(t);
    mode = 2'h1;
    delay = 5 + $urandom % 10;
    next_wake(t, 1, delay + 4);
    next_wake(t, 0, delay + 4);
    mrst_pin = 1'b1;
    repeat (5 * M) @(negedge ref_clk);
    mrst_pin = 1'b0;
    repeat (30 * M) @(negedge ref_clk);
    chk_bit(host_reset_oe, 1'b0);
    mrst_pin = 1'b1;
    p = cyc;
    wait_for(1, 1'b1, at);
    chk(at - p, 15 * M, 6 * M);
    chk_bit(wake_out, 1'b0);
    repeat (40 * M) @(negedge ref_clk);
    mrst_pin = 1'b0;
    p = cyc;
    wait_for(1, 1'b0, t);
    chk(t - p, 335 * M, 5 * M + 4);
    next_wake(t, 1, delay + 4);
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    chk_bit(meas_en, 1'b1);
    mrst_pin = 1'b1;
    p = cyc;
    wait_for(2, 1'b0, at);
    chk(at - p, 15 * M, 6 * M);
    repeat (30 * M) @(negedge ref_clk);
    mrst_pin = 1'b0;
    p = cyc;
    wait_for(2, 1'b1, at);
    chk(at - p, 15 * M, 6 * M);
    // Result below the shortest interval: the design raises it
    meas_interval_ms = 23'h000032;
    iv = 100;
    meas_valid = 1'b1;
    @(negedge ref_clk);
    meas_valid = 1'b0;
    t = cyc;
    chk_bit(host_reset_oe, 1'b0);
    chk_bit(meas_en, 1'b0);
    next_wake(t, M, delay + 4);
    // Converter never answers: timeout falls back to shortest interval
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    p = cyc;
    wait_for(2, 1'b0, t);
    chk(t - p, 120 * M, 1);
    chk_bit(host_reset_oe, 1'b0);
    next_wake(t, 1, delay + 4);
    results();
  end
endmodule // wtw_wake_timer_watchdog_tb
`default_nettype wire
